// ---- rtl/ifp_pkg.sv ----
// package for the interrupt flag and priority bank
package ifp_pkg;
	// ------------------------------------------------------------
	// register byte addresses (word aligned)
	// ------------------------------------------------------------
	localparam logic [7:0] IFP_ADDR_CTRL_TWO   = 8'h00;
	localparam logic [7:0] IFP_ADDR_CTRL_THREE = 8'h04;
	localparam logic [7:0] IFP_ADDR_REQ_ONE    = 8'h08;
	localparam logic [7:0] IFP_ADDR_REQ_TWO    = 8'h0c;
	localparam logic [7:0] IFP_ADDR_ENABLE_ONE = 8'h10;
	localparam logic [7:0] IFP_ADDR_ENABLE_TWO = 8'h14;
	localparam logic [7:0] IFP_ADDR_GLOBAL     = 8'h18;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] IFP_RST_CTRL_TWO   = 8'hff;
	localparam logic [7:0] IFP_RST_CTRL_THREE = 8'hc0;
	localparam logic [7:0] IFP_RST_REQ        = 8'h00;

	// ------------------------------------------------------------
	// control register two fields
	// ------------------------------------------------------------
	localparam int IFP_C2_PULLUP_DIS  = 7;
	localparam int IFP_C2_EDGE_IN0    = 6;
	localparam int IFP_C2_EDGE_IN3    = 3;
	localparam int IFP_C2_TMR0_PRIO   = 2;
	localparam int IFP_C2_IN3_PRIO    = 1;
	localparam int IFP_C2_PCHG_PRIO   = 0;

	// ------------------------------------------------------------
	// control register three fields
	// ------------------------------------------------------------
	localparam int IFP_C3_IN2_PRIO    = 7;
	localparam int IFP_C3_IN1_PRIO    = 6;
	localparam int IFP_C3_EN_LSB      = 3;
	localparam int IFP_C3_FLAG_LSB    = 0;

	// ------------------------------------------------------------
	// request register one fields
	// ------------------------------------------------------------
	localparam int IFP_R1_PARALLEL    = 7;
	localparam int IFP_R1_CONVERSION  = 6;
	localparam int IFP_R1_UART_RX     = 5;
	localparam int IFP_R1_UART_TX     = 4;
	localparam int IFP_R1_SYNC_SER    = 3;
	localparam int IFP_R1_CAPCMP_ONE  = 2;
	localparam int IFP_R1_TMR2_MATCH  = 1;
	localparam int IFP_R1_TMR1_OVF    = 0;
	localparam logic [7:0] IFP_R1_RO_MASK = 8'h30;

	// ------------------------------------------------------------
	// request register two fields
	// ------------------------------------------------------------
	localparam int IFP_R2_OSC_FAIL    = 7;
	localparam int IFP_R2_CMP_TWO     = 6;
	localparam int IFP_R2_CMP_ONE     = 5;
	localparam int IFP_R2_USB         = 4;
	localparam int IFP_R2_BUS_COLL    = 3;
	localparam int IFP_R2_LOW_VOLT    = 2;
	localparam int IFP_R2_TMR3_OVF    = 1;
	localparam int IFP_R2_CAPCMP_TWO  = 0;

	// ------------------------------------------------------------
	// global enable register fields
	// ------------------------------------------------------------
	localparam int IFP_G_GLOBAL       = 1;
	localparam int IFP_G_PERIPH       = 0;

	// ------------------------------------------------------------
	// ahb-lite encodings
	// ------------------------------------------------------------
	localparam logic [1:0] IFP_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] IFP_HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] IFP_HSIZE_WORD    = 3'h2;
endpackage

// ---- rtl/ifp_irq_flag_priority_bank.sv ----
// interrupt control two/three and peripheral request one/two, on ahb-lite
// How it works
// - control two bits 6..3 pick rising (1) or falling (0) edge per input
// - control two bit 7 high disables all port-b pull-ups, else latch decides
// - control two bits 2,1,0 give timer0, input3, port-change priority
// - control three bits 7,6 give input2 and input1 priority
// - control three bits 5,4,3 enable inputs 3,2,1
// - control three bits 2,1,0 are sticky edge flags, software writes zero
// - flags set on their event regardless of any enable
// - reset: control two all ones, control three 0xc0, requests zero
// - request one bit 7 sets on parallel port transfer done
// - request one bit 6 sets on conversion done
// - request one bit 5 read-only, shows uart receive buffer full
// - request one bit 4 read-only, shows uart transmit buffer empty
// - request one bit 3 sets on sync serial transfer done
// - capture/compare flags set on capture or match, not in pwm mode
// - request one bit 1 sets on timer2 period match
// - request one bit 0 and two bit 1 set on timer1/timer3 overflow
// - request two bit 7 sets on oscillator fail switch-over
// - request two bits 6,5 set on comparator 2/1 output change
// - request two bit 4 sets on usb request
// - request two bit 3 sets on sync serial bus collision
// - request two bit 2 sets on core supply low-voltage trip
// - peripheral requests need peripheral enable when priority mode is off
`timescale 1ns/1ps
`default_nettype none

module ifp_irq_flag_priority_bank
	import ifp_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [7:0]  i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// external interrupt pins 3..0 (asynchronous)
	input  wire logic [3:0]  i_ext_in,
	// peripheral event pulses and status levels, same clock
	input  wire logic        i_parallel_port_done,
	input  wire logic        i_conversion_done,
	input  wire logic        i_uart_one_rx_full,
	input  wire logic        i_uart_one_tx_empty,
	input  wire logic        i_sync_serial_one_done,
	input  wire logic        i_capcmp_one_event,
	input  wire logic        i_capcmp_one_pwm_mode,
	input  wire logic        i_timer_two_match,
	input  wire logic        i_timer_one_ovf,
	input  wire logic        i_osc_fail,
	input  wire logic        i_comparator_two_out,
	input  wire logic        i_comparator_one_out,
	input  wire logic        i_usb_request,
	input  wire logic        i_bus_collision_one,
	input  wire logic        i_low_voltage,
	input  wire logic        i_timer_three_ovf,
	input  wire logic        i_capcmp_two_event,
	input  wire logic        i_capcmp_two_pwm_mode,
	// priority mode from the first control register outside this block
	input  wire logic        i_prio_mode,
	// outputs to the vectoring logic and port b
	output logic             o_portb_pullup_disable,
	output logic [3:0]       o_ext_edge_sel,
	output logic             o_timer_zero_ovf_prio,
	output logic             o_port_change_prio,
	output logic [3:1]       o_ext_prio,
	output logic [3:1]       o_ext_en,
	output logic [3:1]       o_ext_flag,
	output logic [7:0]       o_periph_request_one,
	output logic [7:0]       o_periph_request_two,
	output logic             o_periph_irq_req
);

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	logic [3:0] ext_meta;
	logic [3:0] ext_sync;
	logic [3:0] ext_prev;
	logic [3:0] next_ext_meta;
	logic [3:0] next_ext_sync;
	logic [3:0] next_ext_prev;
	logic [3:0] ext_edge;
	logic       cmp_two_prev;
	logic       cmp_one_prev;
	logic       next_cmp_two_prev;
	logic       next_cmp_one_prev;

	// registers
	logic [7:0] irq_control_two;
	logic [7:0] irq_control_three;
	logic [7:0] periph_request_one;
	logic [7:0] periph_request_two;
	logic [7:0] periph_enable_one;
	logic [7:0] periph_enable_two;
	logic [1:0] global_ctrl;
	logic [7:0] next_irq_control_two;
	logic [7:0] next_irq_control_three;
	logic [7:0] next_periph_request_one;
	logic [7:0] next_periph_request_two;
	logic [7:0] next_periph_enable_one;
	logic [7:0] next_periph_enable_two;
	logic [1:0] next_global_ctrl;

	// bus data phase state
	logic       dp_write;
	logic       dp_read;
	logic [7:0] dp_addr;
	logic       next_dp_write;
	logic       next_dp_read;
	logic [7:0] next_dp_addr;
	logic [31:0] next_hrdata;

	logic       addr_ok;
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [3:0] wdat_lo_unused;
	logic [7:0] wbyte;

	// synchroniser chain; first stage only feeds the second
	always_comb begin
		next_ext_meta     = i_ext_in;
		next_ext_sync     = ext_meta;
		next_ext_prev     = ext_sync;
		next_cmp_two_prev = i_comparator_two_out;
		next_cmp_one_prev = i_comparator_one_out;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ext_meta     <= 4'h0;
			ext_sync     <= 4'h0;
			ext_prev     <= 4'h0;
			// track the comparators in reset so release shows no false change
			cmp_two_prev <= i_comparator_two_out;
			cmp_one_prev <= i_comparator_one_out;
		end else begin
			ext_meta     <= next_ext_meta;
			ext_sync     <= next_ext_sync;
			ext_prev     <= next_ext_prev;
			cmp_two_prev <= next_cmp_two_prev;
			cmp_one_prev <= next_cmp_one_prev;
		end
	end

	// selected edge per input: 1 rising, 0 falling
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			ext_edge[i] = irq_control_two[IFP_C2_EDGE_IN0 - i]
				? (ext_sync[i] & ~ext_prev[i])
				: (~ext_sync[i] & ext_prev[i]);
		end
	end

	// ------------------------------------------------------------
	// hardware set events
	// ------------------------------------------------------------
	always_comb begin
		set_one = 8'h00;
		set_two = 8'h00;
		set_one[IFP_R1_PARALLEL]   = i_parallel_port_done;
		set_one[IFP_R1_CONVERSION] = i_conversion_done;
		set_one[IFP_R1_SYNC_SER]   = i_sync_serial_one_done;
		set_one[IFP_R1_CAPCMP_ONE] = i_capcmp_one_event & ~i_capcmp_one_pwm_mode;
		set_one[IFP_R1_TMR2_MATCH] = i_timer_two_match;
		set_one[IFP_R1_TMR1_OVF]   = i_timer_one_ovf;
		set_two[IFP_R2_OSC_FAIL]   = i_osc_fail;
		set_two[IFP_R2_CMP_TWO]    = i_comparator_two_out ^ cmp_two_prev;
		set_two[IFP_R2_CMP_ONE]    = i_comparator_one_out ^ cmp_one_prev;
		set_two[IFP_R2_USB]        = i_usb_request;
		set_two[IFP_R2_BUS_COLL]   = i_bus_collision_one;
		set_two[IFP_R2_LOW_VOLT]   = i_low_voltage;
		set_two[IFP_R2_TMR3_OVF]   = i_timer_three_ovf;
		set_two[IFP_R2_CAPCMP_TWO] = i_capcmp_two_event & ~i_capcmp_two_pwm_mode;
	end

	// ------------------------------------------------------------
	// ahb-lite address phase capture
	// ------------------------------------------------------------
	assign addr_ok = i_hsel & i_hready & i_htrans[1] & (i_hsize == IFP_HSIZE_WORD);

	always_comb begin
		next_dp_write = addr_ok & i_hwrite;
		next_dp_read  = addr_ok & ~i_hwrite;
		next_dp_addr  = addr_ok ? i_haddr : dp_addr;
	end

	// register contents; writes land in the data phase
	always_comb begin
		wbyte          = i_hwdata[7:0];
		wdat_lo_unused = 4'h0;
		next_irq_control_two    = irq_control_two;
		next_irq_control_three  = irq_control_three;
		next_periph_request_one = periph_request_one;
		next_periph_request_two = periph_request_two;
		next_periph_enable_one  = periph_enable_one;
		next_periph_enable_two  = periph_enable_two;
		next_global_ctrl        = global_ctrl;
		if (dp_write) begin
			unique case (dp_addr)
				IFP_ADDR_CTRL_TWO: begin
					next_irq_control_two = wbyte;
				end
				IFP_ADDR_CTRL_THREE: begin
					next_irq_control_three = wbyte;
				end
				IFP_ADDR_REQ_ONE: begin
					// uart bits are not writable
					next_periph_request_one = (wbyte & ~IFP_R1_RO_MASK)
						| (periph_request_one & IFP_R1_RO_MASK);
				end
				IFP_ADDR_REQ_TWO: begin
					next_periph_request_two = wbyte;
				end
				IFP_ADDR_ENABLE_ONE: begin
					next_periph_enable_one = wbyte;
				end
				IFP_ADDR_ENABLE_TWO: begin
					next_periph_enable_two = wbyte;
				end
				IFP_ADDR_GLOBAL: begin
					next_global_ctrl = wbyte[1:0];
				end
				default: begin
					next_global_ctrl = global_ctrl;
				end
			endcase
		end
		// set events applied after the write so they win
		next_irq_control_three[IFP_C3_FLAG_LSB +: 3] =
			next_irq_control_three[IFP_C3_FLAG_LSB +: 3] | ext_edge[3:1];
		next_periph_request_one = next_periph_request_one | set_one;
		next_periph_request_two = next_periph_request_two | set_two;
		// uart status bits follow the buffer state
		next_periph_request_one[IFP_R1_UART_RX] = i_uart_one_rx_full;
		next_periph_request_one[IFP_R1_UART_TX] = i_uart_one_tx_empty;
	end

	// read data registered in the data phase
	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (addr_ok & ~i_hwrite) begin
			unique case (i_haddr)
				IFP_ADDR_CTRL_TWO:   next_hrdata[7:0] = next_irq_control_two;
				IFP_ADDR_CTRL_THREE: next_hrdata[7:0] = next_irq_control_three;
				IFP_ADDR_REQ_ONE:    next_hrdata[7:0] = next_periph_request_one;
				IFP_ADDR_REQ_TWO:    next_hrdata[7:0] = next_periph_request_two;
				IFP_ADDR_ENABLE_ONE: next_hrdata[7:0] = next_periph_enable_one;
				IFP_ADDR_ENABLE_TWO: next_hrdata[7:0] = next_periph_enable_two;
				IFP_ADDR_GLOBAL:     next_hrdata[1:0] = next_global_ctrl;
				default:             next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			irq_control_two    <= IFP_RST_CTRL_TWO;
			irq_control_three  <= IFP_RST_CTRL_THREE;
			periph_request_one <= IFP_RST_REQ;
			periph_request_two <= IFP_RST_REQ;
			periph_enable_one  <= 8'h00;
			periph_enable_two  <= 8'h00;
			global_ctrl        <= 2'h0;
			dp_write           <= 1'b0;
			dp_read            <= 1'b0;
			dp_addr            <= 8'h00;
			o_hrdata           <= 32'h0000_0000;
		end else begin
			irq_control_two    <= next_irq_control_two;
			irq_control_three  <= next_irq_control_three;
			periph_request_one <= next_periph_request_one;
			periph_request_two <= next_periph_request_two;
			periph_enable_one  <= next_periph_enable_one;
			periph_enable_two  <= next_periph_enable_two;
			global_ctrl        <= next_global_ctrl;
			dp_write           <= next_dp_write;
			dp_read            <= next_dp_read;
			dp_addr            <= next_dp_addr;
			o_hrdata           <= next_hrdata;
		end
	end

	// zero wait states, always okay
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	// ------------------------------------------------------------
	// outputs to the rest of the controller
	// ------------------------------------------------------------
	assign o_portb_pullup_disable = irq_control_two[IFP_C2_PULLUP_DIS];
	assign o_ext_edge_sel         = {irq_control_two[IFP_C2_EDGE_IN3],
		irq_control_two[IFP_C2_EDGE_IN3 + 1], irq_control_two[IFP_C2_EDGE_IN3 + 2],
		irq_control_two[IFP_C2_EDGE_IN0]};
	assign o_timer_zero_ovf_prio  = irq_control_two[IFP_C2_TMR0_PRIO];
	assign o_port_change_prio     = irq_control_two[IFP_C2_PCHG_PRIO];
	assign o_ext_prio             = {irq_control_two[IFP_C2_IN3_PRIO],
		irq_control_three[IFP_C3_IN2_PRIO], irq_control_three[IFP_C3_IN1_PRIO]};
	assign o_ext_en               = irq_control_three[IFP_C3_EN_LSB +: 3];
	assign o_ext_flag             = irq_control_three[IFP_C3_FLAG_LSB +: 3];
	assign o_periph_request_one   = periph_request_one;
	assign o_periph_request_two   = periph_request_two;

	// enabled peripheral request, gated by peripheral enable in compat mode
	assign o_periph_irq_req = global_ctrl[IFP_G_GLOBAL]
		& (i_prio_mode | global_ctrl[IFP_G_PERIPH])
		& (|((periph_request_one & periph_enable_one)
		| (periph_request_two & periph_enable_two)));

	// unused write and read-phase bits
	logic unused_ok;
	assign unused_ok = &{1'b0, dp_read, wdat_lo_unused, i_hwdata[31:8], i_htrans[0]};

endmodule

`default_nettype wire

// ---- testbench/ifp_bank_assertions.sv ----
// assertion checker for the interrupt flag and priority bank
`timescale 1ns/1ps
`default_nettype none
module ifp_bank_assertions
	import ifp_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_hsel,
	input wire logic [7:0]  i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [2:0]  i_hsize,
	input wire logic        i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic [3:0]  i_ext_in,
	input wire logic        i_uart_one_rx_full,
	input wire logic        i_uart_one_tx_empty,
	input wire logic        i_timer_one_ovf,
	input wire logic        i_comparator_one_out,
	input wire logic        o_portb_pullup_disable,
	input wire logic [3:0]  o_ext_edge_sel,
	input wire logic [3:1]  o_ext_prio,
	input wire logic [3:1]  o_ext_en,
	input wire logic [3:1]  o_ext_flag,
	input wire logic [7:0]  o_periph_request_one,
	input wire logic [7:0]  o_periph_request_two
);
	// ------------------------------
	// bus data phase tracking
	// ------------------------------
	logic       take;
	logic       dp_wr, dp_rd, next_dp_wr, next_dp_rd;
	logic [7:0] dp_addr, next_dp_addr;
	assign take = i_hsel && i_hready && i_htrans[1] && i_hsize == IFP_HSIZE_WORD;
	// next data phase kind and address
	always_comb begin
		next_dp_wr = !i_rst && take && i_hwrite;
		next_dp_rd = !i_rst && take && !i_hwrite;
		next_dp_addr = i_haddr;
	end
	// register the data phase state
	always_ff @(posedge i_clk_sys) begin
		dp_wr <= next_dp_wr;
		dp_rd <= next_dp_rd;
		dp_addr <= next_dp_addr;
	end
	// ------------------------------
	// properties
	// ------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_in1_rise;
		!i_ext_in[1] ##1 i_ext_in[1] && o_ext_edge_sel[1] ##1 i_ext_in[1] [*2];
	endsequence
	sequence s_in2_fall;
		i_ext_in[2] ##1 !i_ext_in[2] && !o_ext_edge_sel[2] ##1 !i_ext_in[2] [*2];
	endsequence
	property p_reset_vals;
		$fell(i_rst) |-> o_portb_pullup_disable && o_ext_edge_sel == 4'hf && o_ext_prio == 3'h7
			&& {o_ext_en, o_ext_flag} == 6'h00 && (o_periph_request_one & ~IFP_R1_RO_MASK) == 8'h00
			&& o_periph_request_two == 8'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	property p_tmr1_set;
		i_timer_one_ovf |=> o_periph_request_one[IFP_R1_TMR1_OVF];
	endproperty
	a_tmr1_set: assert property (p_tmr1_set) else $error("overflow flag not set");
	property p_osc_sticky;
		o_periph_request_two[IFP_R2_OSC_FAIL] && !(dp_wr && dp_addr == IFP_ADDR_REQ_TWO)
			|=> o_periph_request_two[IFP_R2_OSC_FAIL];
	endproperty
	a_osc_sticky: assert property (p_osc_sticky) else $error("flag dropped without write");
	property p_uart_mirror;
		!i_rst |=> o_periph_request_one[5:4] == $past({i_uart_one_rx_full, i_uart_one_tx_empty});
	endproperty
	a_uart_mirror: assert property (p_uart_mirror) else $error("uart bits do not follow");
	property p_cmp_change;
		!$past(i_rst) && $changed(i_comparator_one_out) |=> o_periph_request_two[IFP_R2_CMP_ONE];
	endproperty
	a_cmp_change: assert property (p_cmp_change) else $error("comparator flag not set");
	property p_read_ctl3;
		dp_rd && dp_addr == IFP_ADDR_CTRL_THREE && !$past(dp_wr)
			|-> o_hrdata == {24'h0, o_ext_prio[2:1], o_ext_en, o_ext_flag};
	endproperty
	a_read_ctl3: assert property (p_read_ctl3) else $error("control three read wrong");
	property p_in1_rise;
		s_in1_rise |-> ##[0:2] o_ext_flag[1];
	endproperty
	a_in1_rise: assert property (p_in1_rise) else $error("rising edge missed");
	property p_in2_fall;
		s_in2_fall |-> ##[0:2] o_ext_flag[2];
	endproperty
	a_in2_fall: assert property (p_in2_fall) else $error("falling edge missed");
endmodule
bind ifp_irq_flag_priority_bank ifp_bank_assertions u_chk (.*);
`default_nettype wire

// ---- testbench/ifp_periph_model.sv ----
// peripheral event source and uart buffer model for the flag bank
`timescale 1ns/1ps
`default_nettype none
module ifp_periph_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic [15:0] i_fire,
	input  wire logic [3:0]  i_uart,
	output logic      [15:0] o_pulse,
	output logic             o_cmp_two,
	output logic             o_cmp_one,
	output logic             o_rx_full,
	output logic             o_tx_empty
);
	// events last one cycle, comparator outputs flip on request
	always_ff @(posedge i_clk_sys) begin
		o_pulse <= i_rst ? 16'h0000 : i_fire;
		o_cmp_two <= !i_rst && (o_cmp_two ^ i_fire[14]);
		o_cmp_one <= !i_rst && (o_cmp_one ^ i_fire[13]);
	end
	// bit 0 loads, bit 1 reads receive; bit 2 writes, bit 3 drains transmit
	always_ff @(posedge i_clk_sys) begin
		o_rx_full <= !i_rst && (o_rx_full || i_uart[0]) && !i_uart[1];
		o_tx_empty <= i_rst || ((o_tx_empty || i_uart[3]) && !i_uart[2]);
	end
endmodule
`default_nettype wire

// ---- testbench/irq_flag_priority_bank_tb_top.sv ----
// self-checking bench for the interrupt flag and priority bank
`timescale 1ns/1ps
`default_nettype none
module irq_flag_priority_bank_tb_top;
	import ifp_pkg::*;
	typedef struct packed {logic [15:0] f; logic [15:0] e;} ifp_row_s;
	logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_hwrite = 1'b0, i_prio_mode = 1'b0;
	logic        i_capcmp_one_pwm_mode = 1'b0, i_capcmp_two_pwm_mode = 1'b0;
	logic [7:0]  i_haddr = 8'h00, o_periph_request_one, o_periph_request_two;
	logic [1:0]  i_htrans = 2'h0;
	logic [2:0]  i_hsize = IFP_HSIZE_WORD;
	logic [31:0] i_hwdata = 32'h0, o_hrdata, smp_rd, rd;
	logic [3:0]  i_ext_in = 4'h0, i_uart = 4'h0, o_ext_edge_sel;
	logic [15:0] i_fire = 16'h0, o_pulse;
	logic [3:1]  o_ext_prio, o_ext_en, o_ext_flag;
	logic        o_hreadyout, o_hresp, smp_rdy, o_cmp_two, o_cmp_one, o_rx_full, o_tx_empty;
	logic        o_portb_pullup_disable, o_timer_zero_ovf_prio, o_port_change_prio, o_periph_irq_req;
	int          err_count = 0, checks = 0, cycles = 0;
	ifp_row_s    rows [14] = '{'{16'h0001, 16'h0001}, '{16'h0002, 16'h0002}, '{16'h0004, 16'h0004},
		'{16'h0008, 16'h0008}, '{16'h0040, 16'h0040}, '{16'h0080, 16'h0080}, '{16'h0100, 16'h0100},
		'{16'h0200, 16'h0200}, '{16'h0400, 16'h0400}, '{16'h0800, 16'h0800}, '{16'h1000, 16'h1000},
		'{16'h2000, 16'h2000}, '{16'h4000, 16'h4000}, '{16'h8000, 16'h8000}};
	// event sources and the design
	ifp_periph_model u_src (.*);
	ifp_irq_flag_priority_bank dut (.*, .i_hsel(1'b1), .i_hready(o_hreadyout),
		.i_parallel_port_done(o_pulse[7]), .i_conversion_done(o_pulse[6]), .i_sync_serial_one_done(o_pulse[3]),
		.i_capcmp_one_event(o_pulse[2]), .i_timer_two_match(o_pulse[1]), .i_timer_one_ovf(o_pulse[0]),
		.i_osc_fail(o_pulse[15]), .i_comparator_two_out(o_cmp_two), .i_comparator_one_out(o_cmp_one),
		.i_usb_request(o_pulse[12]), .i_bus_collision_one(o_pulse[11]), .i_low_voltage(o_pulse[10]),
		.i_timer_three_ovf(o_pulse[9]), .i_capcmp_two_event(o_pulse[8]),
		.i_uart_one_rx_full(o_rx_full), .i_uart_one_tx_empty(o_tx_empty));
	// clock, pre-edge sampling of the bus, run limit
	initial begin
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	always @(negedge i_clk_sys) begin
		smp_rdy = o_hreadyout;
		smp_rd = o_hrdata;
	end
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			give_verdict();
		end
	end
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic give_verdict;
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [15:0] f);
		@(posedge i_clk_sys);
		i_haddr <= a;
		i_hwrite <= w;
		i_htrans <= IFP_HTRANS_NONSEQ;
		i_fire <= f;
		do @(posedge i_clk_sys); while (!smp_rdy);
		i_htrans <= 2'h0;
		i_hwdata <= {24'h0, d};
		i_fire <= 16'h0;
		do @(posedge i_clk_sys); while (!smp_rdy);
		rd = smp_rd;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 16'h0);
		chk(rd, {24'h0, e}, "register");
	endtask
	task automatic pin(input logic [3:0] v, input logic [2:0] e);
		@(posedge i_clk_sys);
		i_ext_in <= v;
		repeat (6) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk(32'(o_ext_flag), 32'(e), "pin flags");
	endtask
	task automatic ua(input logic [3:0] v);
		@(posedge i_clk_sys);
		i_uart <= v;
		@(posedge i_clk_sys);
		i_uart <= 4'h0;
		repeat (2) @(posedge i_clk_sys);
	endtask
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rchk(IFP_ADDR_CTRL_TWO, 8'hff);
		rchk(IFP_ADDR_CTRL_THREE, 8'hc0);
		rchk(IFP_ADDR_REQ_ONE, 8'h10);
		rchk(IFP_ADDR_REQ_TWO, 8'h00);
		chk(32'(o_portb_pullup_disable), 32'h1, "pullup off");
		// each event source sets its own flag, then software clears
		foreach (rows[i]) begin
			bus(1'b0, IFP_ADDR_REQ_ONE, 8'h00, rows[i].f);
			rchk(IFP_ADDR_REQ_ONE, rows[i].e[7:0] | 8'h10);
			rchk(IFP_ADDR_REQ_TWO, rows[i].e[15:8]);
			bus(1'b1, IFP_ADDR_REQ_ONE, 8'h00, 16'h0);
			bus(1'b1, IFP_ADDR_REQ_TWO, 8'h00, 16'h0);
		end
		bus(1'b1, IFP_ADDR_CTRL_TWO, 8'h28, 16'h0);
		bus(1'b1, IFP_ADDR_CTRL_THREE, 8'ha8, 16'h0);
		@(negedge i_clk_sys);
		chk(32'({o_portb_pullup_disable, o_ext_edge_sel, o_timer_zero_ovf_prio, o_ext_prio[3], o_port_change_prio}),
			32'h50, "control two outputs");
		chk(32'({o_ext_prio[2:1], o_ext_en, o_ext_flag}), 32'ha8, "control three outputs");
		rchk(IFP_ADDR_CTRL_TWO, 8'h28);
		pin(4'h4, 3'h0);
		pin(4'h6, 3'h1);
		pin(4'he, 3'h5);
		pin(4'ha, 3'h7);
		pin(4'h8, 3'h7);
		bus(1'b1, IFP_ADDR_CTRL_THREE, 8'ha8, 16'h0);
		pin(4'h8, 3'h0);
		bus(1'b1, IFP_ADDR_REQ_ONE, 8'h00, 16'h0001);
		rchk(IFP_ADDR_REQ_ONE, 8'h11);
		bus(1'b1, IFP_ADDR_REQ_ONE, 8'h00, 16'h0);
		ua(4'h1);
		rchk(IFP_ADDR_REQ_ONE, 8'h30);
		bus(1'b1, IFP_ADDR_REQ_ONE, 8'h00, 16'h0);
		rchk(IFP_ADDR_REQ_ONE, 8'h30);
		ua(4'h2);
		ua(4'h4);
		rchk(IFP_ADDR_REQ_ONE, 8'h00);
		ua(4'h8);
		rchk(IFP_ADDR_REQ_ONE, 8'h10);
		i_capcmp_one_pwm_mode <= 1'b1;
		i_capcmp_two_pwm_mode <= 1'b1;
		bus(1'b0, IFP_ADDR_REQ_ONE, 8'h00, 16'h0104);
		rchk(IFP_ADDR_REQ_ONE, 8'h10);
		rchk(IFP_ADDR_REQ_TWO, 8'h00);
		bus(1'b0, IFP_ADDR_REQ_ONE, 8'h00, 16'h0001);
		bus(1'b1, IFP_ADDR_ENABLE_ONE, 8'h01, 16'h0);
		bus(1'b1, IFP_ADDR_GLOBAL, 8'h02, 16'h0);
		@(negedge i_clk_sys);
		chk(32'(o_periph_irq_req), 32'h0, "irq no periph enable");
		bus(1'b1, IFP_ADDR_GLOBAL, 8'h03, 16'h0);
		@(negedge i_clk_sys);
		chk(32'(o_periph_irq_req), 32'h1, "irq enabled");
		bus(1'b1, IFP_ADDR_GLOBAL, 8'h02, 16'h0);
		i_prio_mode <= 1'b1;
		@(negedge i_clk_sys);
		chk(32'(o_periph_irq_req), 32'h1, "irq priority mode");
		bus(1'b1, 8'h1c, 8'hff, 16'h0);
		rchk(8'h1c, 8'h00);
		// second reset in mid-run, comparators high until the model clears them in reset
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(negedge i_clk_sys);
		chk(32'({o_hreadyout, o_hresp}), 32'h2, "bus response after reset");
		rchk(IFP_ADDR_CTRL_TWO, 8'hff);
		rchk(IFP_ADDR_REQ_TWO, 8'h00);
		rchk(IFP_ADDR_GLOBAL, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
